// [hw/qdsr_defines.svh]
// constants of the quad dac serial command and readback core
// assumes: included by its bare name from the package, the buffer bank and the core
`ifndef QDSR_DEFINES_SVH
`define QDSR_DEFINES_SVH

// ----------------------------------------------------------------------------
// widths and frame counts
// ----------------------------------------------------------------------------
`define QDSR_DATA_W 16
`define QDSR_SPAN_W 4
`define QDSR_CHANS 4
`define QDSR_FRAME_SHORT 6'h18
`define QDSR_FRAME_LONG 6'h20
`define QDSR_HDR_LAST_SHORT 6'h07
`define QDSR_HDR_LAST_LONG 6'h0F
`define QDSR_COUNT_MAX 6'h3F

// ----------------------------------------------------------------------------
// command field codes
// ----------------------------------------------------------------------------
`define QDSR_CMD_WR_SPAN 4'h2
`define QDSR_CMD_WR_CODE 4'h3
`define QDSR_CMD_UPD_ONE 4'h4
`define QDSR_CMD_UPD_ALL 4'h5
`define QDSR_CMD_WR_SPAN_UPD 4'h6
`define QDSR_CMD_WR_CODE_UPD 4'h7
`define QDSR_CMD_WR_SPAN_UPD_ALL 4'h8
`define QDSR_CMD_WR_CODE_UPD_ALL 4'h9
`define QDSR_CMD_RD_HOLD_SPAN 4'hA
`define QDSR_CMD_RD_HOLD_CODE 4'hB
`define QDSR_CMD_RD_ACT_SPAN 4'hC
`define QDSR_CMD_RD_ACT_CODE 4'hD
`define QDSR_CMD_SLEEP 4'hE
`define QDSR_CMD_NOP 4'hF

// ----------------------------------------------------------------------------
// channel select field codes
// ----------------------------------------------------------------------------
`define QDSR_ADDR_A 4'h0
`define QDSR_ADDR_B 4'h2
`define QDSR_ADDR_C 4'h4
`define QDSR_ADDR_D 4'h6
`define QDSR_ADDR_ALL 4'hF

// ----------------------------------------------------------------------------
// readback pointer buffer selects and reset values
// ----------------------------------------------------------------------------
`define QDSR_SEL_HOLD_SPAN 2'h0
`define QDSR_SEL_HOLD_CODE 2'h1
`define QDSR_SEL_ACT_SPAN 2'h2
`define QDSR_SEL_ACT_CODE 2'h3
`define QDSR_PTR_RESET 4'h3
`define QDSR_SLEEP_RESET 4'h0

`endif

// [hw/qdsr_pkg.sv]
// types and word formatting shared by the core and its buffer bank
// assumes: qdsr_defines.svh is reachable by its bare name
package qdsr_pkg;

`include "qdsr_defines.svh"

  // ----------------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------------
  // one channel: holding and active code and span
  typedef struct packed
  {
    logic [`QDSR_DATA_W-1:0] holdCode;
    logic [`QDSR_DATA_W-1:0] actCode;
    logic [`QDSR_SPAN_W-1:0] holdSpan;
    logic [`QDSR_SPAN_W-1:0] actSpan;
  } qdsr_chan_t;

  // readback pointer: channel and buffer select
  typedef struct packed
  {
    logic [1:0] chan;
    logic [1:0] sel;
  } qdsr_ptr_t;

  // ----------------------------------------------------------------------------
  // readback word layout
  // ----------------------------------------------------------------------------
  // span in the last four bits, sleep bit just before them
  function automatic logic [`QDSR_DATA_W-1:0] qdsrFormat(input qdsr_chan_t ch, input logic [1:0] sel,
                                                          input logic sleep_status_bit);
    logic [`QDSR_DATA_W-1:0] w;
    begin
      w = {`QDSR_DATA_W{1'b0}};
      case (sel)
        `QDSR_SEL_HOLD_SPAN: w = {11'h000, sleep_status_bit, ch.holdSpan};
        `QDSR_SEL_HOLD_CODE: w = ch.holdCode;
        `QDSR_SEL_ACT_SPAN: w = {11'h000, sleep_status_bit, ch.actSpan};
        default: w = ch.actCode;
      endcase
      return w;
    end
  endfunction

endpackage

// [hw/qdsr_sync.sv]
// two-flop level synchroniser into the system clock domain
// assumes: din is a level from a pin or another clock domain
`timescale 1ns/1ps

module qdsr_sync
#(
  parameter logic RESET_VAL = 1'b1
)
(
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic din, // asynchronous level
  output logic dout // synchronised level
);

  logic stage1;

  // first flop feeds only the second
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

// [hw/qdsr_buffer_bank.sv]
// holding and active buffers of the four channels with a registered read port
// assumes: strobes are one-cycle pulses or levels from the system clock domain
`timescale 1ns/1ps
`include "qdsr_defines.svh"

module qdsr_buffer_bank
(
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [`QDSR_CHANS-1:0] wrSpan, // write holding span per channel
  input wire logic [`QDSR_CHANS-1:0] wrCode, // write holding code per channel
  input wire logic [`QDSR_CHANS-1:0] update, // copy holding to active per channel
  input wire logic zeroAll, // clear all active buffers
  input wire logic [`QDSR_DATA_W-1:0] wrData, // data field of the command
  input wire logic [`QDSR_CHANS-1:0] sleep, // sleep status per channel
  input wire qdsr_pkg::qdsr_ptr_t rdPtr, // readback pointer
  output qdsr_pkg::qdsr_chan_t [`QDSR_CHANS-1:0] chans, // all buffers
  output logic [`QDSR_DATA_W-1:0] rollWord // registered rolling readback word
);
  import qdsr_pkg::*;

  logic [`QDSR_CHANS-1:0][`QDSR_DATA_W-1:0] holdCode;
  logic [`QDSR_CHANS-1:0][`QDSR_DATA_W-1:0] actCode;
  logic [`QDSR_CHANS-1:0][`QDSR_SPAN_W-1:0] holdSpan;
  logic [`QDSR_CHANS-1:0][`QDSR_SPAN_W-1:0] actSpan;
  logic [`QDSR_CHANS-1:0][`QDSR_DATA_W-1:0] next_holdCode;
  logic [`QDSR_CHANS-1:0][`QDSR_SPAN_W-1:0] next_holdSpan;

  // holding values including a write in this cycle
  always_comb
  begin
    for (int i = 0; i < `QDSR_CHANS; i++)
    begin
      next_holdCode[i] = wrCode[i] ? wrData : holdCode[i];
      next_holdSpan[i] = wrSpan[i] ? wrData[`QDSR_SPAN_W-1:0] : holdSpan[i];
    end
  end

  // holding buffers: writes only, outputs untouched
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      holdCode <= '0;
      holdSpan <= '0;
    end
    else
    begin
      holdCode <= next_holdCode;
      holdSpan <= next_holdSpan;
    end
  end

  // active buffers: changed by update or cleared, clear wins
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      actCode <= '0;
      actSpan <= '0;
    end
    else
    begin
      for (int i = 0; i < `QDSR_CHANS; i++)
      begin
        if (zeroAll)
        begin
          actCode[i] <= '0;
          actSpan[i] <= '0;
        end
        else if (update[i])
        begin
          actCode[i] <= next_holdCode[i];
          actSpan[i] <= next_holdSpan[i];
        end
      end
    end
  end

  // gather the buffers per channel
  always_comb
  begin
    for (int i = 0; i < `QDSR_CHANS; i++)
    begin
      chans[i] = '{holdCode: holdCode[i], actCode: actCode[i], holdSpan: holdSpan[i], actSpan: actSpan[i]};
    end
  end

  // registered read of the word the pointer names
  always_ff @(posedge clock)
  begin
    if (rst)
      rollWord <= '0;
    else
      rollWord <= qdsrFormat(chans[rdPtr.chan], rdPtr.sel, sleep[rdPtr.chan]);
  end

endmodule

// [hw/qdsr_core.sv]
// serial command, update and readback core of a quad voltage-output dac
// assumes: linkClock is the host's serial clock; the host keeps
// selectAndLoadN high for at least eight system clocks between frames
`timescale 1ns/1ps
`include "qdsr_defines.svh"

module qdsr_core
(
  input wire logic clock, // system clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic linkClock, // serial clock from the host
  input wire logic selectAndLoadN, // frame select, low while framed
  input wire logic serialDataIn, // serial command data
  output logic serialReadbackOut, // readback data
  output logic serialReadbackOe, // readback drive enable
  input wire logic asyncUpdateN, // update all while low
  input wire logic asyncZeroN, // clear active buffers while low
  output logic resetIndicatorN, // low after reset or clear
  output logic [`QDSR_CHANS-1:0][`QDSR_DATA_W-1:0] activeCode, // active codes
  output logic [`QDSR_CHANS-1:0][`QDSR_SPAN_W-1:0] activeSpan, // active spans
  output logic [`QDSR_CHANS-1:0] sleepStatus // sleep status per channel
);
  import qdsr_pkg::*;

  // ----------------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------------
  // channel field to {valid, mask, pointer channel}
  function automatic logic [6:0] decodeChan(input logic [3:0] addr);
    logic [6:0] r;
    begin
      r = 7'h00;
      case (addr)
        `QDSR_ADDR_A: r = {1'b1, 4'h1, 2'h0};
        `QDSR_ADDR_B: r = {1'b1, 4'h2, 2'h1};
        `QDSR_ADDR_C: r = {1'b1, 4'h4, 2'h2};
        `QDSR_ADDR_D: r = {1'b1, 4'h8, 2'h3};
        `QDSR_ADDR_ALL: r = {1'b1, 4'hF, 2'h0};
        default: r = 7'h00;
      endcase
      return r;
    end
  endfunction

  // command to {known, next pointer select}
  function automatic logic [2:0] cmdPtrSel(input logic [3:0] cmd);
    logic [2:0] r;
    begin
      r = 3'h0;
      case (cmd)
        `QDSR_CMD_WR_SPAN: r = {1'b1, `QDSR_SEL_HOLD_SPAN};
        `QDSR_CMD_WR_CODE: r = {1'b1, `QDSR_SEL_HOLD_CODE};
        `QDSR_CMD_UPD_ONE: r = {1'b1, `QDSR_SEL_ACT_SPAN};
        `QDSR_CMD_UPD_ALL: r = {1'b1, `QDSR_SEL_ACT_CODE};
        `QDSR_CMD_WR_SPAN_UPD: r = {1'b1, `QDSR_SEL_ACT_SPAN};
        `QDSR_CMD_WR_CODE_UPD: r = {1'b1, `QDSR_SEL_ACT_CODE};
        `QDSR_CMD_WR_SPAN_UPD_ALL: r = {1'b1, `QDSR_SEL_ACT_SPAN};
        `QDSR_CMD_WR_CODE_UPD_ALL: r = {1'b1, `QDSR_SEL_ACT_CODE};
        `QDSR_CMD_RD_HOLD_SPAN: r = {1'b1, `QDSR_SEL_HOLD_SPAN};
        `QDSR_CMD_RD_HOLD_CODE: r = {1'b1, `QDSR_SEL_HOLD_CODE};
        `QDSR_CMD_RD_ACT_SPAN: r = {1'b1, `QDSR_SEL_ACT_SPAN};
        `QDSR_CMD_RD_ACT_CODE: r = {1'b1, `QDSR_SEL_ACT_CODE};
        `QDSR_CMD_SLEEP: r = {1'b1, `QDSR_SEL_ACT_SPAN};
        `QDSR_CMD_NOP: r = {1'b1, `QDSR_SEL_ACT_CODE};
        default: r = 3'h0;
      endcase
      return r;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------------------
  logic [31:0] shiftReg;
  logic [5:0] bitCount;
  logic [5:0] lastLength;
  logic mode32;
  logic headerDone;
  logic [`QDSR_DATA_W-1:0] rbWord;
  logic [`QDSR_DATA_W-1:0] outShift;
  logic rbStarted;
  logic [7:0] inByte;
  logic [6:0] hdrChan;
  logic [2:0] hdrPtr;
  logic [`QDSR_DATA_W-1:0] pickWord;
  qdsr_chan_t [`QDSR_CHANS-1:0] chans;
  logic [`QDSR_DATA_W-1:0] rollWord;

  // serial shift register, held while deselected
  always_ff @(posedge linkClock)
  begin
    if (!selectAndLoadN)
      shiftReg <= {shiftReg[30:0], serialDataIn};
  end

  // bits in this frame, cleared by deselect
  always_ff @(posedge linkClock or posedge selectAndLoadN)
  begin
    if (selectAndLoadN)
      bitCount <= 6'h00;
    else if (bitCount != `QDSR_COUNT_MAX)
      bitCount <= bitCount + 6'h01;
  end

  // length of the last frame, kept for the decode side
  always_ff @(posedge linkClock)
  begin
    if (!selectAndLoadN)
      lastLength <= (bitCount == `QDSR_COUNT_MAX) ? bitCount : bitCount + 6'h01;
  end

  // header byte as it completes on this edge
  assign inByte = {shiftReg[6:0], serialDataIn};
  assign hdrChan = decodeChan(inByte[3:0]);
  assign hdrPtr = cmdPtrSel(inByte[7:4]); // read codes map onto buffer selects

  // read commands pick any buffer, others roll the pointer's word
  always_comb
  begin
    pickWord = rollWord;
    if (inByte[7:4] >= `QDSR_CMD_RD_HOLD_SPAN && inByte[7:4] <= `QDSR_CMD_RD_ACT_CODE && hdrChan[6])
      pickWord = qdsrFormat(chans[hdrChan[1:0]], hdrPtr[1:0], sleepStatus[hdrChan[1:0]]);
  end

  // frame format and header capture
  always_ff @(posedge linkClock or posedge selectAndLoadN)
  begin
    if (selectAndLoadN)
    begin
      mode32 <= 1'b0;
      headerDone <= 1'b0;
      rbWord <= '0;
    end
    else if (!headerDone)
    begin
      if (bitCount == `QDSR_HDR_LAST_SHORT)
      begin
        if (inByte == 8'h00)
          mode32 <= 1'b1;
        else
        begin
          headerDone <= 1'b1;
          rbWord <= pickWord;
        end
      end
      else if (bitCount == `QDSR_HDR_LAST_LONG && mode32)
      begin
        headerDone <= 1'b1;
        rbWord <= pickWord;
      end
    end
  end

  // readback shifter on falling edges, low until data is due
  always_ff @(negedge linkClock or posedge selectAndLoadN)
  begin
    if (selectAndLoadN)
    begin
      serialReadbackOut <= 1'b0;
      outShift <= '0;
      rbStarted <= 1'b0;
    end
    else if (headerDone && !rbStarted)
    begin
      serialReadbackOut <= rbWord[`QDSR_DATA_W-1];
      outShift <= {rbWord[`QDSR_DATA_W-2:0], 1'b0};
      rbStarted <= 1'b1;
    end
    else if (rbStarted)
    begin
      serialReadbackOut <= outShift[`QDSR_DATA_W-1];
      outShift <= {outShift[`QDSR_DATA_W-2:0], 1'b0};
    end
  end

  // pin driven only while selected
  assign serialReadbackOe = !selectAndLoadN;

  // ----------------------------------------------------------------------------
  // pin synchronisers into the system clock
  // ----------------------------------------------------------------------------
  logic selSync;
  logic updSyncN;
  logic zeroSyncN;
  logic selPrev;

  qdsr_sync #(.RESET_VAL(1'b1)) selSyncInst
  (
    .clock(clock),
    .rst(rst),
    .din(selectAndLoadN),
    .dout(selSync)
  );

  qdsr_sync #(.RESET_VAL(1'b1)) updSyncInst
  (
    .clock(clock),
    .rst(rst),
    .din(asyncUpdateN),
    .dout(updSyncN)
  );

  qdsr_sync #(.RESET_VAL(1'b1)) zeroSyncInst
  (
    .clock(clock),
    .rst(rst),
    .din(asyncZeroN),
    .dout(zeroSyncN)
  );

  // select history for the end-of-frame edge
  always_ff @(posedge clock)
  begin
    if (rst)
      selPrev <= 1'b1;
    else
      selPrev <= selSync;
  end

  // ----------------------------------------------------------------------------
  // command decode at end of frame
  // ----------------------------------------------------------------------------
  logic frameEnd;
  logic lengthOk;
  logic execute;
  logic [3:0] cmdField;
  logic [3:0] chanField;
  logic [`QDSR_DATA_W-1:0] dataField;
  logic [6:0] chanDec;
  logic [2:0] ptrDec;
  logic [`QDSR_CHANS-1:0] wrSpan;
  logic [`QDSR_CHANS-1:0] wrCode;
  logic [`QDSR_CHANS-1:0] cmdUpdate;
  logic [`QDSR_CHANS-1:0] update;
  logic [`QDSR_CHANS-1:0] sleepSet;
  qdsr_ptr_t rdPtr;

  // shift register is static here: select has been high two clocks
  assign frameEnd = selSync && !selPrev;
  assign lengthOk = (lastLength == `QDSR_FRAME_SHORT) || (lastLength == `QDSR_FRAME_LONG);
  assign cmdField = shiftReg[23:20];
  assign chanField = shiftReg[19:16];
  assign dataField = shiftReg[15:0];
  assign chanDec = decodeChan(cmdField == `QDSR_CMD_UPD_ALL ? `QDSR_ADDR_ALL : chanField);
  assign ptrDec = cmdPtrSel(cmdField);
  assign execute = frameEnd && lengthOk && chanDec[6] && ptrDec[2];

  // write, update and sleep strobes
  always_comb
  begin
    wrSpan = '0;
    wrCode = '0;
    cmdUpdate = '0;
    sleepSet = '0;
    if (execute)
    begin
      case (cmdField)
        `QDSR_CMD_WR_SPAN: wrSpan = chanDec[5:2];
        `QDSR_CMD_WR_CODE: wrCode = chanDec[5:2];
        `QDSR_CMD_UPD_ONE: cmdUpdate = chanDec[5:2];
        `QDSR_CMD_UPD_ALL: cmdUpdate = 4'hF;
        `QDSR_CMD_WR_SPAN_UPD:
        begin
          wrSpan = chanDec[5:2];
          cmdUpdate = chanDec[5:2];
        end
        `QDSR_CMD_WR_CODE_UPD:
        begin
          wrCode = chanDec[5:2];
          cmdUpdate = chanDec[5:2];
        end
        `QDSR_CMD_WR_SPAN_UPD_ALL:
        begin
          wrSpan = chanDec[5:2];
          cmdUpdate = 4'hF;
        end
        `QDSR_CMD_WR_CODE_UPD_ALL:
        begin
          wrCode = chanDec[5:2];
          cmdUpdate = 4'hF;
        end
        `QDSR_CMD_SLEEP: sleepSet = chanDec[5:2];
        default: sleepSet = '0;
      endcase
    end
  end

  // async update acts as update all while low
  assign update = cmdUpdate | (updSyncN ? 4'h0 : 4'hF);

  // readback pointer left for the next frame
  always_ff @(posedge clock)
  begin
    if (rst)
      rdPtr <= `QDSR_PTR_RESET;
    else if (execute)
      rdPtr <= '{chan: chanDec[1:0], sel: ptrDec[1:0]};
  end

  // ----------------------------------------------------------------------------
  // sleep and reset flag
  // ----------------------------------------------------------------------------
  // sleep set by command, cleared by update, set wins
  always_ff @(posedge clock)
  begin
    if (rst)
      sleepStatus <= `QDSR_SLEEP_RESET;
    else
      sleepStatus <= (sleepStatus & ~update) | sleepSet;
  end

  // flag low on reset or clear, high after an update
  always_ff @(posedge clock)
  begin
    if (rst)
      resetIndicatorN <= 1'b0;
    else if (!zeroSyncN)
      resetIndicatorN <= 1'b0;
    else if (update != 4'h0)
      resetIndicatorN <= 1'b1;
  end

  // ----------------------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------------------
  qdsr_buffer_bank bankInst
  (
    .clock(clock),
    .rst(rst),
    .wrSpan(wrSpan),
    .wrCode(wrCode),
    .update(update),
    .zeroAll(!zeroSyncN),
    .wrData(dataField),
    .sleep(sleepStatus),
    .rdPtr(rdPtr),
    .chans(chans),
    .rollWord(rollWord)
  );

  // active buffers drive the channel outputs
  always_comb
  begin
    for (int i = 0; i < `QDSR_CHANS; i++)
    begin
      activeCode[i] = chans[i].actCode;
      activeSpan[i] = chans[i].actSpan;
    end
  end

endmodule

// [dv/qdsr_host_model.sv]
// host side of the serial link: frames words, gathers readback
// assumes: sro is the resolved readback wire; clock stands still between frames
`timescale 1ns/1ps
module qdsr_host_model
(
  output logic linkClock, // serial clock
  output logic selectAndLoadN, // frame select
  output logic serialDataIn, // serial data
  input wire logic serial_readback_out // readback wire
);
  // idle: clock low, select high
  initial
  begin
    linkClock = 1'b0;
    selectAndLoadN = 1'b0;
    serialDataIn = 1'b0;
    #1 selectAndLoadN = 1'b1; // clean rise clears the link-side counters
  end
  // one frame of len bits, msb first, 32 ns clock
  task automatic frame(input int len, input logic [31:0] w, output logic [15:0] rb, output logic pre);
    pre = 1'b0;
    rb = 16'h0000;
    selectAndLoadN = 1'b0;
    #16;
    for (int k = 1; k <= len; k++)
    begin
      serialDataIn = w[len-k];
      #16 linkClock = 1'b1;
      if (k > len - 16)
        rb = {rb[14:0], serial_readback_out};
      else
        pre = pre | serial_readback_out;
      #16 linkClock = 1'b0;
    end
    selectAndLoadN = 1'b1;
    serialDataIn = ~serialDataIn; // line no longer holds last bit
  endtask
endmodule

// [dv/qdsr_core_props.sv]
// port assertions of qdsr_core
// assumes: bound into qdsr_core, system clock domain only
`timescale 1ns/1ps
module qdsr_core_props
(
  input wire logic clock, // system clock
  input wire logic rst, // sync reset
  input wire logic selectAndLoadN, // frame select
  input wire logic serialReadbackOut, // readback data
  input wire logic serialReadbackOe, // readback enable
  input wire logic asyncUpdateN, // async update
  input wire logic asyncZeroN, // async clear
  input wire logic resetIndicatorN, // reset flag
  input wire logic [3:0][15:0] activeCode, // active codes
  input wire logic [3:0][3:0] activeSpan, // active spans
  input wire logic [3:0] sleepStatus // sleep flags
);
  import qdsr_pkg::*;
  // one domain: shared clock, and shared disable except in a_reset_flag
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_oe_follows_select: assert property (serialReadbackOe == !selectAndLoadN)
    else $error("readback enable not tied to select");
  a_idle_out_low: assert property (selectAndLoadN && $past(selectAndLoadN) |-> !serialReadbackOut)
    else $error("readback data high while deselected");
  a_clear_zeroes: assert property ($fell(asyncZeroN) |-> ##[1:5] (activeCode == 64'h0 && !resetIndicatorN))
    else $error("clear did not zero outputs");
  a_clear_holds: assert property (!asyncZeroN && !$past(asyncZeroN, 4) |-> activeSpan == 16'h0)
    else $error("span not held at zero");
  a_reset_flag: assert property (disable iff (1'b0) rst |=> !resetIndicatorN && activeCode == 64'h0)
    else $error("reset left flag or code");
  a_update_wakes: assert property ($fell(asyncUpdateN) && asyncZeroN |-> ##[1:5] (resetIndicatorN && sleepStatus == 4'h0))
    else $error("async update did not wake or raise flag");
  a_active_held: assert property (!selectAndLoadN && !$past(selectAndLoadN) && asyncUpdateN && asyncZeroN |-> $stable(activeCode) && $stable(activeSpan))
    else $error("active buffer moved in frame");
  a_sleep_held: assert property (!selectAndLoadN && !$past(selectAndLoadN) |-> $stable(sleepStatus))
    else $error("sleep moved in frame");
  c_clear: cover property ($fell(asyncZeroN));
  c_wake: cover property ($fell(|sleepStatus));
  c_flag_up: cover property ($rose(resetIndicatorN));
endmodule

bind qdsr_core qdsr_core_props props_u
(
  .clock(clock),
  .rst(rst),
  .selectAndLoadN(selectAndLoadN),
  .serialReadbackOut(serialReadbackOut),
  .serialReadbackOe(serialReadbackOe),
  .asyncUpdateN(asyncUpdateN),
  .asyncZeroN(asyncZeroN),
  .resetIndicatorN(resetIndicatorN),
  .activeCode(activeCode),
  .activeSpan(activeSpan),
  .sleepStatus(sleepStatus)
);

// [dv/qdsr_core_tb.sv]
// self-checking bench of qdsr_core against a behavioural model
// assumes: host model drives the link, 125 MHz system clock
`timescale 1ns/1ps
module qdsr_core_tb;
  import qdsr_pkg::*;
  logic clock, rst, asyncUpdateN, asyncZeroN, serialReadbackOut, serialReadbackOe, resetIndicatorN, pre, flag;
  wire linkClock, selectAndLoadN, serialDataIn, serial_readback_out;
  logic [3:0][15:0] activeCode;
  logic [3:0][3:0] activeSpan;
  logic [3:0] sleepStatus, sleep_status_bit;
  logic [15:0] hc[4], ac[4], rb, ex;
  logic [3:0] hs[4], asp[4];
  logic [3:0] adr[6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hF, 4'h1};
  int pc, ps, num_errors, samples_checked, seed, cyc = 0;
  assign serial_readback_out = serialReadbackOe ? serialReadbackOut : 1'bz;
  qdsr_host_model host_u (.linkClock(linkClock), .selectAndLoadN(selectAndLoadN), .serialDataIn(serialDataIn), .serial_readback_out(serial_readback_out));
  qdsr_core dut_u (.clock(clock), .rst(rst), .linkClock(linkClock), .selectAndLoadN(selectAndLoadN),
    .serialDataIn(serialDataIn), .serialReadbackOut(serialReadbackOut), .serialReadbackOe(serialReadbackOe),
    .asyncUpdateN(asyncUpdateN), .asyncZeroN(asyncZeroN), .resetIndicatorN(resetIndicatorN),
    .activeCode(activeCode), .activeSpan(activeSpan), .sleepStatus(sleepStatus));
  // system clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // readback word of one buffer
  function automatic logic [15:0] wd(int c, int s);
    case (s)
      0: return {11'h000, sleep_status_bit[c], hs[c]};
      1: return hc[c];
      2: return {11'h000, sleep_status_bit[c], asp[c]};
      default: return ac[c];
    endcase
  endfunction
  // copy all holding to active, wake all
  task automatic updAll();
    for (int i = 0; i < 4; i++)
    begin
      asp[i] = hs[i];
      ac[i] = hc[i];
    end
    sleep_status_bit = 4'h0;
    flag = 1'b1;
  endtask
  task automatic cmpOut();
    chk("code", activeCode, {ac[3], ac[2], ac[1], ac[0]});
    chk("span", activeSpan, {asp[3], asp[2], asp[1], asp[0]});
    chk("sleep", sleepStatus, sleep_status_bit);
    chk("flag", resetIndicatorN, flag);
  endtask
  // one framed command, model update, then compare
  task automatic op(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d, input int len);
    logic [3:0] m;
    int n;
    if (c == 5)
      a = 4'hF;
    if (c == 0)
      len = 32;
    if (c == 2 || c == 6 || c == 8)
      d = d % 6;
    m = (a == 4'hF) ? 4'hF : (a[0] | a[3]) ? 4'h0 : 4'h1 << a[2:1];
    n = (a == 4'hF) ? 0 : a[2:1];
    ex = (c >= 10 && c <= 13 && m != 0) ? wd(n, c - 10) : wd(pc, ps);
    host_u.frame(len, {8'h00, c, a, d}, rb, pre);
    chk("readback", rb, ex);
    chk("lead", pre, 0);
    if (m != 0 && c >= 2)
    begin
      for (int i = 0; i < 4; i++)
        if (m[i])
        begin
          if (c == 2 || c == 6 || c == 8)
            hs[i] = d[3:0];
          if (c == 3 || c == 7 || c == 9)
            hc[i] = d;
          if (c == 4 || c == 6 || c == 7)
          begin
            asp[i] = hs[i];
            ac[i] = hc[i];
            sleep_status_bit[i] = 1'b0;
          end
          if (c == 14)
            sleep_status_bit[i] = 1'b1;
        end
      if (c == 5 || c == 8 || c == 9)
        updAll();
      if (c >= 4 && c <= 9)
        flag = 1'b1;
      ps = (c >= 10 && c <= 13) ? c - 10 : (c < 4) ? c - 2 : c[0] ? 3 : 2;
      pc = n;
    end
    tick(10);
    chk("released", serial_readback_out, 1'bz);
    cmpOut();
  endtask
  // async clear or update pulse, select high
  task automatic pulse(input logic z);
    if (z)
      asyncZeroN = 1'b0;
    else
      asyncUpdateN = 1'b0;
    tick(7);
    asyncZeroN = 1'b1;
    asyncUpdateN = 1'b1;
    if (z)
      for (int i = 0; i < 4; i++)
      begin
        asp[i] = 4'h0;
        ac[i] = 16'h0000;
        flag = 1'b0;
      end
    else
      updAll();
    tick(10);
    cmpOut();
  endtask
  // main sequence
  initial
  begin
    rst = 1'b1;
    asyncUpdateN = 1'b1;
    asyncZeroN = 1'b1;
    seed = 32'hEEEB;
    num_errors = 0;
    samples_checked = 0;
    pc = 0;
    ps = 3;
    sleep_status_bit = 4'h0;
    flag = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      hc[i] = 16'h0000;
      ac[i] = 16'h0000;
      hs[i] = 4'h0;
      asp[i] = 4'h0;
    end
    tick(10);
    rst = 1'b0;
    tick(4);
    cmpOut();
    for (int c = 0; c < 16; c++)
      op(4'(c), 4'h2, 16'($random(seed)), 24);
    op(4'hC, 4'h2, 16'h0000, 24);
    for (int i = 0; i < 160; i++)
    begin
      op(4'($random(seed)), adr[$unsigned($random(seed)) % 6], 16'($random(seed)), ($random(seed) & 1) ? 32 : 24);
      if (i % 20 == 9)
        pulse(1'b0);
      if (i % 30 == 19)
        pulse(1'b1);
    end
    close_out();
  end
endmodule
